/* File: rtl/analog_routing_config.sv */
// APB register bank steering analog column muxes, buffers, modulators.
// Assumes an APB master on the same clock; zero wait states.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
module analog_routing_config (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire analog_routing_pkg::modulators_type mod_sources,
  input wire logic [1:0] gain_sign_bit,
  output analog_routing_pkg::col_switch_type col_switch,
  output logic col1_source_choice,
  output logic col2_source_choice,
  output logic col0_outbuf_on,
  output logic col1_outbuf_on,
  output logic col2_outbuf_on,
  output logic col3_outbuf_on,
  output logic outbuf_drive_level,
  output logic [1:0] modulating,
  output logic [1:0] gain_polarity
);

  // ************************************************************
  // Register state
  // ************************************************************
  analog_routing_pkg::input_select_type input_select;
  analog_routing_pkg::input_select_type next_input_select;
  analog_routing_pkg::route_ctrl_type route_ctrl;
  analog_routing_pkg::route_ctrl_type next_route_ctrl;
  logic [3:0] mod_ctrl;
  logic [3:0] next_mod_ctrl;
  logic [31:0] next_prdata;
  logic [31:0] read_value;
  logic [7:0] index;
  logic hit;
  logic wr_access;

  // ************************************************************
  // Address decode
  // ************************************************************
  assign index = paddr[9:2];
  assign wr_access = psel & penable & pwrite & hit;

  always_comb begin
    hit = 1'b0;
    read_value = 32'h0000_0000;
    if (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0) begin
      case (index)
        analog_routing_pkg::IDX_INPUT_SELECT: begin
          hit = 1'b1;
          read_value = {24'h00_0000, input_select};
        end
        analog_routing_pkg::IDX_OUTBUF_CONTROL: begin
          // Write-only, reads back zero
          hit = 1'b1;
        end
        analog_routing_pkg::IDX_MODULATOR_CONTROL: begin
          hit = 1'b1;
          read_value = {28'h000_0000, mod_ctrl};
        end
        analog_routing_pkg::IDX_ROUTING_STATUS: begin
          hit = 1'b1;
          read_value = {28'h000_0000, modulating, gain_polarity};
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // APB answer
  // ************************************************************
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    next_input_select = input_select;
    next_route_ctrl = route_ctrl;
    next_mod_ctrl = mod_ctrl;
    next_prdata = prdata;
    if (wr_access) begin
      if (index == analog_routing_pkg::IDX_INPUT_SELECT) begin
        next_input_select = pwdata[7:0];
      end
      if (index == analog_routing_pkg::IDX_OUTBUF_CONTROL) begin
        next_route_ctrl.col1_source_choice =
          pwdata[analog_routing_pkg::POS_COL1_CHOICE];
        next_route_ctrl.col2_source_choice =
          pwdata[analog_routing_pkg::POS_COL2_CHOICE];
        next_route_ctrl.outbuf_on = {
          pwdata[analog_routing_pkg::POS_BUF3],
          pwdata[analog_routing_pkg::POS_BUF2],
          pwdata[analog_routing_pkg::POS_BUF1],
          pwdata[analog_routing_pkg::POS_BUF0]};
        // Bit 1 is dropped, software keeps it zero
        next_route_ctrl.outbuf_drive_level =
          pwdata[analog_routing_pkg::POS_DRIVE];
      end
      if (index == analog_routing_pkg::IDX_MODULATOR_CONTROL) begin
        next_mod_ctrl = pwdata[3:0];
      end
    end
    if (psel & ~penable & ~pwrite) begin
      next_prdata = read_value;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      input_select <= analog_routing_pkg::RESET_INPUT_SELECT;
      // Reserved bit 1 is not stored, drive level sits lowest
      route_ctrl <= {analog_routing_pkg::RESET_OUTBUF_CONTROL[7:2],
        analog_routing_pkg::RESET_OUTBUF_CONTROL[0]};
      mod_ctrl <= analog_routing_pkg::RESET_MODULATOR_CONTROL;
      prdata <= 32'h0000_0000;
    end else begin
      input_select <= next_input_select;
      route_ctrl <= next_route_ctrl;
      mod_ctrl <= next_mod_ctrl;
      prdata <= next_prdata;
    end
  end

  // ************************************************************
  // Outputs straight from the control register
  // ************************************************************
  assign col1_source_choice = route_ctrl.col1_source_choice;
  assign col2_source_choice = route_ctrl.col2_source_choice;
  assign col0_outbuf_on = route_ctrl.outbuf_on[0];
  assign col1_outbuf_on = route_ctrl.outbuf_on[1];
  assign col2_outbuf_on = route_ctrl.outbuf_on[2];
  assign col3_outbuf_on = route_ctrl.outbuf_on[3];
  assign outbuf_drive_level = route_ctrl.outbuf_drive_level;

  // ************************************************************
  // Column routing and modulation
  // ************************************************************
  column_route u_route (
    .clock(clock),
    .srst(srst),
    .sel(input_select),
    .ctrl(route_ctrl),
    .col_switch(col_switch)
  );

  // Only columns 0 and 2 carry a modulator
  modulation_polarity u_mod_col0 (
    .clock(clock),
    .srst(srst),
    .mod_select(mod_ctrl[analog_routing_pkg::POS_COL0_MOD+:2]),
    .sources(mod_sources),
    .gain_sign_bit(gain_sign_bit[0]),
    .modulating(modulating[0]),
    .gain_polarity(gain_polarity[0])
  );

  modulation_polarity u_mod_col2 (
    .clock(clock),
    .srst(srst),
    .mod_select(mod_ctrl[analog_routing_pkg::POS_COL2_MOD+:2]),
    .sources(mod_sources),
    .gain_sign_bit(gain_sign_bit[1]),
    .modulating(modulating[1]),
    .gain_polarity(gain_polarity[1])
  );

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_write_to(logic [7:0] idx);
    psel && penable && pwrite && paddr == {2'h0, idx, 2'h0};
  endsequence

  property p_col3_route;
    @(posedge clock) disable iff (srst)
    !$past(srst) |->
      col_switch[3] == (8'h01 << {$past(input_select.col3_port_select),
      1'b0});
  endproperty
  a_col3_route: assert property (p_col3_route)
    else $error("column 3 switch does not follow its select");

  property p_col2_route;
    @(posedge clock) disable iff (srst)
    (!$past(srst) && !$past(route_ctrl.col2_source_choice)) |->
      col_switch[2] == (8'h02 << {$past(input_select.col2_port_select),
      1'b0});
  endproperty
  a_col2_route: assert property (p_col2_route)
    else $error("column 2 switch does not follow its select");

  property p_col1_route;
    @(posedge clock) disable iff (srst)
    (!$past(srst) && !$past(route_ctrl.col1_source_choice)) |->
      col_switch[1] == (8'h01 << {$past(input_select.col1_port_select),
      1'b0});
  endproperty
  a_col1_route: assert property (p_col1_route)
    else $error("column 1 switch does not follow its select");

  property p_col0_route;
    @(posedge clock) disable iff (srst)
    !$past(srst) |->
      col_switch[0] == (8'h02 << {$past(input_select.col0_port_select),
      1'b0});
  endproperty
  a_col0_route: assert property (p_col0_route)
    else $error("column 0 switch does not follow its select");

  property p_one_pin;
    @(posedge clock) disable iff (srst)
    $onehot(col_switch[0]) && $onehot(col_switch[1]) &&
    $onehot(col_switch[2]) && $onehot(col_switch[3]);
  endproperty
  a_one_pin: assert property (p_one_pin)
    else $error("a column closes other than one port switch");

  property p_col1_choice;
    @(posedge clock) disable iff (srst)
    $past(route_ctrl.col1_source_choice) && !$past(srst) |->
      col_switch[1] == col_switch[0];
  endproperty
  a_col1_choice: assert property (p_col1_choice)
    else $error("column 1 does not take column 0 mux");

  property p_col2_choice;
    @(posedge clock) disable iff (srst)
    $past(route_ctrl.col2_source_choice) && !$past(srst) |->
      col_switch[2] == col_switch[3];
  endproperty
  a_col2_choice: assert property (p_col2_choice)
    else $error("column 2 does not take column 3 mux");

  property p_outbuf_write;
    @(posedge clock) disable iff (srst)
    s_write_to(analog_routing_pkg::IDX_OUTBUF_CONTROL) |=>
      ({col1_outbuf_on, col2_outbuf_on, col0_outbuf_on, col3_outbuf_on}
      == $past(pwdata[5:2])) ##1
      $stable({col1_outbuf_on, col2_outbuf_on, col0_outbuf_on,
      col3_outbuf_on});
  endproperty
  a_outbuf_write: assert property (p_outbuf_write)
    else $error("buffer enables do not match the written bits");

  property p_drive_level;
    @(posedge clock) disable iff (srst)
    s_write_to(analog_routing_pkg::IDX_OUTBUF_CONTROL) |=>
      outbuf_drive_level == $past(pwdata[0]);
  endproperty
  a_drive_level: assert property (p_drive_level)
    else $error("drive level does not match the written bit");

  property p_col2_block03;
    @(posedge clock) disable iff (srst)
    mod_ctrl[3:2] == analog_routing_pkg::MOD_BLOCK03 |=>
      modulating[1] == $past(mod_sources.block03_out);
  endproperty
  a_col2_block03: assert property (p_col2_block03)
    else $error("column 2 does not follow block 03 output");

  property p_col0_global4;
    @(posedge clock) disable iff (srst)
    mod_ctrl[1:0] == analog_routing_pkg::MOD_GLOBAL4 |=>
      modulating[0] == $past(mod_sources.global_out4);
  endproperty
  a_col0_global4: assert property (p_col0_global4)
    else $error("column 0 does not follow global output 4");

  property p_polarity;
    @(posedge clock) disable iff (srst)
    !$past(srst) |->
      gain_polarity == ($past(gain_sign_bit) ^ modulating);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("gain polarity is not sign xor modulating");

  property p_reset_clear;
    @(posedge clock)
    srst ##1 1'b1 |-> route_ctrl == 7'h00 && mod_ctrl == 4'h0 &&
      input_select == 8'h00 && modulating == 2'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("registers are not clear after reset");

endmodule // analog_routing_config

/* File: rtl/analog_routing_pkg.sv */
// Constants, field layout and carrier types of the analog routing bank.
// Assumes a single 10 MHz clock domain and an APB register bus.
package analog_routing_pkg;

  // ************************************************************
  // Register indices, byte address is four times the index
  // ************************************************************
  localparam int ADDR_WIDTH = 12;
  localparam logic [7:0] IDX_INPUT_SELECT = 8'h60;
  localparam logic [7:0] IDX_OUTBUF_CONTROL = 8'h62;
  localparam logic [7:0] IDX_MODULATOR_CONTROL = 8'h63;
  localparam logic [7:0] IDX_ROUTING_STATUS = 8'h66;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RESET_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RESET_OUTBUF_CONTROL = 8'h00;
  localparam logic [3:0] RESET_MODULATOR_CONTROL = 4'h0;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int POS_COL1_CHOICE = 7;
  localparam int POS_COL2_CHOICE = 6;
  localparam int POS_BUF1 = 5;
  localparam int POS_BUF2 = 4;
  localparam int POS_BUF0 = 3;
  localparam int POS_BUF3 = 2;
  localparam int POS_DRIVE = 0;
  localparam int POS_COL2_MOD = 2;
  localparam int POS_COL0_MOD = 0;

  // ************************************************************
  // Modulation source encodings
  // ************************************************************
  localparam logic [1:0] MOD_NONE = 2'h0;
  localparam logic [1:0] MOD_GLOBAL0 = 2'h1;
  localparam logic [1:0] MOD_GLOBAL4 = 2'h2;
  localparam logic [1:0] MOD_BLOCK03 = 2'h3;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [1:0] col3_port_select;
    logic [1:0] col2_port_select;
    logic [1:0] col1_port_select;
    logic [1:0] col0_port_select;
  } input_select_type;

  typedef struct packed {
    logic col1_source_choice;
    logic col2_source_choice;
    logic [3:0] outbuf_on;
    logic outbuf_drive_level;
  } route_ctrl_type;

  typedef struct packed {
    logic global_out0;
    logic global_out4;
    logic block03_out;
  } modulators_type;

  typedef logic [3:0][7:0] col_switch_type;

endpackage

/* File: rtl/column_route.sv */
// Port-bit switch enables of the four analog column inputs.
// Assumes select fields come from registers on the same clock.
`timescale 1ns/1ns
module column_route (
  input wire logic clock,
  input wire logic srst,
  input wire analog_routing_pkg::input_select_type sel,
  input wire analog_routing_pkg::route_ctrl_type ctrl,
  output analog_routing_pkg::col_switch_type col_switch
);

  logic [7:0] sel_bits;
  analog_routing_pkg::col_switch_type stage;
  analog_routing_pkg::col_switch_type next_col_switch;

  assign sel_bits = sel;

  // ************************************************************
  // First stage: four port bits per column
  // ************************************************************
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_stage
      // Odd columns take even port bits, even columns odd ones
      localparam logic [2:0] LANE = (c % 2 == 0) ? 3'h1 : 3'h0;
      logic [2:0] bit_index;
      assign bit_index = {sel_bits[2*c+:2], 1'b0} | LANE;
      assign stage[c] = 8'h01 << bit_index;
    end
  endgenerate

  // ************************************************************
  // Second stage for columns 1 and 2
  // ************************************************************
  always_comb begin
    next_col_switch = stage;
    if (ctrl.col1_source_choice) begin
      next_col_switch[1] = stage[0];
    end
    if (ctrl.col2_source_choice) begin
      next_col_switch[2] = stage[3];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      col_switch <= {8'h01, 8'h02, 8'h01, 8'h02};
    end else begin
      col_switch <= next_col_switch;
    end
  end

endmodule // column_route

/* File: rtl/modulation_polarity.sv */
// Gain polarity of one modulated switched-capacitor column.
// Assumes modulating sources are logic on the same clock.
`timescale 1ns/1ns
module modulation_polarity (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] mod_select,
  input wire analog_routing_pkg::modulators_type sources,
  input wire logic gain_sign_bit,
  output logic modulating,
  output logic gain_polarity
);

  logic next_modulating;
  logic next_gain_polarity;

  always_comb begin
    unique case (mod_select)
      analog_routing_pkg::MOD_NONE: next_modulating = 1'b0;
      analog_routing_pkg::MOD_GLOBAL0: next_modulating = sources.global_out0;
      analog_routing_pkg::MOD_GLOBAL4: next_modulating = sources.global_out4;
      analog_routing_pkg::MOD_BLOCK03: next_modulating = sources.block03_out;
    endcase
    // High modulating level inverts the configured sign
    next_gain_polarity = gain_sign_bit ^ next_modulating;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      modulating <= 1'b0;
      gain_polarity <= 1'b0;
    end else begin
      modulating <= next_modulating;
      gain_polarity <= next_gain_polarity;
    end
  end

endmodule // modulation_polarity

/* File: tb/analog_far_side.sv */
// Far side of the routing bank: modulating sources and gain sign bits.
// Assumes the bench pulses step for one clock to get a new pattern.
`timescale 1ns/1ns
module analog_far_side (
  input wire logic clock,
  input wire logic step,
  output analog_routing_pkg::modulators_type mod_sources,
  output logic [1:0] gain_sign_bit
);
  int seed = 22378;
  logic [4:0] next_pick;

  // ************************************************************
  // Source levels, held until the next step
  // ************************************************************
  initial begin
    mod_sources = 3'h0;
    gain_sign_bit = 2'h0;
    next_pick = 5'h00;
  end

  always @(posedge clock) begin
    if (step) begin
      next_pick = 5'($random(seed));
      mod_sources <= next_pick[2:0];
      gain_sign_bit <= next_pick[4:3];
    end
  end
endmodule // analog_far_side

/* File: tb/analog_routing_config_test.sv */
// Self-checking bench of the analog routing register bank.
// Assumes zero-wait APB and the far-side model in analog_far_side.
`timescale 1ns/1ns
module analog_routing_config_test;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic step = 1'b0;
  logic snap = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  analog_routing_pkg::modulators_type mod_sources;
  logic [1:0] gain_sign_bit;
  analog_routing_pkg::col_switch_type col_switch;
  logic col1_source_choice;
  logic col2_source_choice;
  logic col0_outbuf_on;
  logic col1_outbuf_on;
  logic col2_outbuf_on;
  logic col3_outbuf_on;
  logic outbuf_drive_level;
  logic [1:0] modulating;
  logic [1:0] gain_polarity;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 22378;
  logic [7:0] r_in = 8'h00;
  logic [7:0] r_buf = 8'h00;
  logic [3:0] r_mod = 4'h0;
  logic [32:0] e_rd;
  logic [32:0] q_rd[$];
  logic [42:0] q_out[$];

  always #50 clock = ~clock;

  analog_routing_config dut_u (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mod_sources(mod_sources), .gain_sign_bit(gain_sign_bit),
    .col_switch(col_switch), .col1_source_choice(col1_source_choice),
    .col2_source_choice(col2_source_choice),
    .col0_outbuf_on(col0_outbuf_on), .col1_outbuf_on(col1_outbuf_on),
    .col2_outbuf_on(col2_outbuf_on), .col3_outbuf_on(col3_outbuf_on),
    .outbuf_drive_level(outbuf_drive_level), .modulating(modulating),
    .gain_polarity(gain_polarity));

  analog_far_side far_u (.clock(clock), .step(step),
    .mod_sources(mod_sources), .gain_sign_bit(gain_sign_bit));

  // ************************************************************
  // Expected outputs from the shadow registers
  // ************************************************************
  function automatic logic pick(input logic [1:0] c);
    case (c)
      2'h1: return mod_sources.global_out0;
      2'h2: return mod_sources.global_out4;
      2'h3: return mod_sources.block03_out;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [42:0] model();
    logic [7:0] m0, m1, m2, m3;
    logic [1:0] md;
    m0 = 8'h02 << {r_in[1:0], 1'b0};
    m1 = 8'h01 << {r_in[3:2], 1'b0};
    m2 = 8'h02 << {r_in[5:4], 1'b0};
    m3 = 8'h01 << {r_in[7:6], 1'b0};
    md = {pick(r_mod[3:2]), pick(r_mod[1:0])};
    return {m3, r_buf[6] ? m3 : m2, r_buf[7] ? m0 : m1, m0, r_buf[7],
      r_buf[6], r_buf[3], r_buf[5], r_buf[4], r_buf[2], r_buf[0], md,
      md ^ gain_sign_bit};
  endfunction

  // ************************************************************
  // Drivers
  // ************************************************************
  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [1:0] lo, input logic [31:0] wd, input logic [32:0] ex);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, lo};
    pwdata <= wd;
    q_rd.push_back(ex);
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, 2'h0, {24'($random(seed)), d}, 33'h0_0000_0000);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b0, idx, 2'h0, 32'h0000_0000, {25'h0000000, d});
  endtask

  task automatic check_outs();
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge clock);
    q_out.push_back(model());
    snap <= 1'b1;
    @(posedge clock);
    snap <= 1'b0;
  endtask

  // ************************************************************
  // Monitor and comparisons
  // ************************************************************
  task automatic cmp_rd(input logic w, input logic [32:0] e,
      input logic [32:0] g);
    if (w) begin
      e[31:0] = 32'h0000_0000;
      g[31:0] = 32'h0000_0000;
    end
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] apb response expected %h seen %h", e, g);
    end
  endtask

  task automatic cmp_out(input logic [42:0] e, input logic [42:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] routing outputs expected %h seen %h", e, g);
    end
  endtask

  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && q_rd.size() > 0) begin
      e_rd = q_rd.pop_front();
      cmp_rd(pwrite, e_rd, {pslverr, prdata});
    end
    if (snap && q_out.size() > 0) begin
      cmp_out(q_out.pop_front(), {col_switch, col1_source_choice,
        col2_source_choice, col0_outbuf_on, col1_outbuf_on, col2_outbuf_on,
        col3_outbuf_on, outbuf_drive_level, modulating, gain_polarity});
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    check_outs();
    rd(analog_routing_pkg::IDX_INPUT_SELECT, 8'h00);
    rd(analog_routing_pkg::IDX_MODULATOR_CONTROL, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      r_in = {4{c[1:0]}};
      wr(analog_routing_pkg::IDX_INPUT_SELECT, r_in);
      rd(analog_routing_pkg::IDX_INPUT_SELECT, r_in);
      check_outs();
    end
    $display("test column codes done");
    for (int i = 0; i < 14; i++) begin
      r_in = 8'($random(seed));
      r_buf = (i < 8) ? (8'h01 << i) : 8'($random(seed));
      r_buf = r_buf & 8'hFD;
      wr(analog_routing_pkg::IDX_INPUT_SELECT, r_in);
      wr(analog_routing_pkg::IDX_OUTBUF_CONTROL, r_buf);
      rd(analog_routing_pkg::IDX_OUTBUF_CONTROL, 8'h00);
      check_outs();
    end
    $display("test buffer control done");
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 3; k++) begin
        r_mod = {c[1:0], 2'(3 - c - k)};
        wr(analog_routing_pkg::IDX_MODULATOR_CONTROL, {4'hF, r_mod});
        rd(analog_routing_pkg::IDX_MODULATOR_CONTROL,
          {4'h0, r_mod});
        psel <= 1'b0;
        penable <= 1'b0;
        step <= 1'b1;
        @(posedge clock);
        step <= 1'b0;
        check_outs();
        rd(analog_routing_pkg::IDX_ROUTING_STATUS,
          {4'h0, 4'(model())});
      end
    end
    $display("test modulation done");
    apb(1'b1, 8'h61, 2'h0, 32'h0000_00FF, 33'h1_0000_0000);
    apb(1'b0, 8'h61, 2'h0, 32'h0000_0000, 33'h1_0000_0000);
    apb(1'b1, analog_routing_pkg::IDX_INPUT_SELECT, 2'h1, 32'h0000_00FF,
      33'h1_0000_0000);
    rd(analog_routing_pkg::IDX_INPUT_SELECT, r_in);
    check_outs();
    $display("test unmapped access done");
    r_buf = 8'h3D;
    wr(analog_routing_pkg::IDX_OUTBUF_CONTROL, r_buf);
    check_outs();
    psel <= 1'b0;
    penable <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    r_in = 8'h00;
    r_buf = 8'h00;
    r_mod = 4'h0;
    check_outs();
    rd(analog_routing_pkg::IDX_INPUT_SELECT, 8'h00);
    check_outs();
    $display("test mid-run reset done");
    test_done();
  end

  initial begin
    #(100 * 4000);
    n_errors++;
    $display("watchdog expired");
    test_done();
  end
endmodule // analog_routing_config_test
